// >>> core/rsc_map.vh
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define RSC_ADDR_W 14
`define RSC_DATA_W 32

// ----------------------------------------
// Register indices, byte address = 4 x index
// ----------------------------------------
`define RSC_IDX_CAUSE 12'hFCC
`define RSC_IDX_CONFIG 12'hFDE
`define RSC_IDX_COMMIT 12'hFDF
`define RSC_IDX_IRQ_STAT 12'hFE0
`define RSC_IDX_IRQ_MASK 12'hFE1

// ----------------------------------------
// Commit codes
// ----------------------------------------
`define RSC_CODE_DISABLE 8'hB2
`define RSC_CODE_FIELDS 8'hD4
`define RSC_CODE_FLAGCLR 8'h71

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define RSC_CFG_W 3
`define RSC_CFG_DIS 0
`define RSC_CFG_B1 1
`define RSC_CFG_B2 2
`define RSC_CAUSE_W 7
`define RSC_FCLR_BIT 7
`define RSC_EVT_W 8
`define RSC_EVT_EXT 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RSC_CFG_RST 3'h0
`define RSC_CAUSE_RST 7'h00
`define RSC_EVT_RST 8'h00
`define RSC_RESET_VECTOR 16'hFFFE

`endif

// >>> core/rsc_reset_ctrl.v
// Function
// - merge external and six internal reset sources
// - config holds three RW fields, upper zero
// - disable bit effective only after code B2
// - code D4 commits fields in bits 2,1
// - code 71 commits flag clear; others ignored
// - only power-on resets effective disable bit
// - every reset clears written config contents
// - status reads effective fields, bit0 disable
// - status shares commit address, upper zero
// - cause flags set by matching reset source
// - bit 5 shows abnormal trim data detected
// - flags cleared by power-on, external, commit
// - committed clear zeroes flags and clear bit
// - flag clear bit always reads zero
// - after release start warm-up, vector fetch
`timescale 1ns/100ps
`include "rsc_map.vh"

module rsc_reset_ctrl (
   // Clock and bus reset
   input wire clock,
   input wire srst,
   // Avalon-MM slave
   input wire [`RSC_ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [`RSC_DATA_W-1:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [`RSC_DATA_W-1:0] avs_readdata,
   output wire avs_waitrequest,
   // Reset sources
   input wire por_req,
   input wire ext_reset_n_pin,
   input wire vdet1_req,
   input wire vdet2_req,
   input wire watchdog_req,
   input wire sysclk_req,
   input wire trim_req,
   input wire flash_standby_req,
   input wire bad_trim_in,
   // Reset outputs
   output reg sys_reset,
   output reg por_reset,
   output reg warmup_start,
   output reg [15:0] reset_vector,
   // Effective configuration
   output reg ext_reset_disable_effective,
   output reg config_field_b1_effective,
   output reg config_field_b2_effective,
   // Interrupt
   output wire irq
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   // Pin synchroniser and bus handshake
   reg ext_sync1_reg;
   reg ext_sync2_reg;
   reg ack_reg;
   // Register storage
   reg [`RSC_CFG_W-1:0] cfg_wr_reg;
   reg fclr_reg;
   reg [`RSC_CAUSE_W-1:0] cause_reg;
   reg [`RSC_EVT_W-1:0] evt_stat_reg;
   reg [`RSC_EVT_W-1:0] evt_mask_reg;
   reg [7:0] rd_next;
   // Bus decode
   wire [11:0] word_idx;
   wire req;
   wire take;
   wire wr_take;
   wire [7:0] wdata;
   wire sel_cause;
   wire sel_config;
   wire sel_commit;
   wire sel_stat;
   wire sel_mask;
   // Reset merge and commit strobes
   wire por_any;
   wire ext_req;
   wire int_any;
   wire any_reset;
   wire commit_dis;
   wire commit_fields;
   wire commit_fclr;
   wire flag_clear;
   // Source vectors
   wire [`RSC_CAUSE_W-1:0] cause_src;
   wire [`RSC_EVT_W-1:0] evt_src;
   wire [`RSC_CFG_W-1:0] cfg_eff;

   // ----------------------------------------
   // External pin synchroniser
   // ----------------------------------------
   // Pin is asynchronous; only the second stage is used below
   always @(posedge clock) begin
      if (srst) begin
         ext_sync1_reg <= 1'b1;
         ext_sync2_reg <= 1'b1;
      end else begin
         ext_sync1_reg <= ext_reset_n_pin;
         ext_sync2_reg <= ext_sync1_reg;
      end
   end

   // ----------------------------------------
   // Reset source merge
   // ----------------------------------------
   // Bus reset is treated as a power-on reset of this block
   assign por_any = srst | por_req;
   // Pin low resets unless the committed disable bit blocks it
   assign ext_req = ~ext_sync2_reg &
      ~ext_reset_disable_effective;
   assign int_any = vdet1_req | vdet2_req | watchdog_req |
      sysclk_req | trim_req | flash_standby_req;
   assign any_reset = por_any | ext_req | int_any;

   // Registered so downstream logic never sees a merge glitch
   always @(posedge clock) begin
      if (srst) begin
         sys_reset <= 1'b1;
      end else begin
         sys_reset <= any_reset;
      end
   end

   // Power-on view kept apart for parts that only it resets
   always @(posedge clock) begin
      if (srst) begin
         por_reset <= 1'b1;
      end else begin
         por_reset <= por_req;
      end
   end

   // ----------------------------------------
   // Release handling
   // ----------------------------------------
   // Warm-up itself lives in the clock generator; this pulse
   // starts it, and the vector tells the core where to fetch
   always @(posedge clock) begin
      if (srst) begin
         warmup_start <= 1'b0;
      end else begin
         warmup_start <= sys_reset & ~any_reset;
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         reset_vector <= `RSC_RESET_VECTOR;
      end else begin
         reset_vector <= `RSC_RESET_VECTOR;
      end
   end

   // ----------------------------------------
   // Avalon-MM handshake
   // ----------------------------------------
   // One wait state: data is muxed in the first cycle and
   // stands registered at the edge where waitrequest is low
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_reg;
   assign take = req & ack_reg;
   assign wr_take = take & avs_write & avs_byteenable[0];
   assign wdata = avs_writedata[7:0];
   assign word_idx = avs_address[`RSC_ADDR_W-1:2];

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // One byte register per word; all upper index bits must match
   assign sel_cause = (word_idx == `RSC_IDX_CAUSE);
   assign sel_config = (word_idx == `RSC_IDX_CONFIG);
   assign sel_commit = (word_idx == `RSC_IDX_COMMIT);
   assign sel_stat = (word_idx == `RSC_IDX_IRQ_STAT);
   assign sel_mask = (word_idx == `RSC_IDX_IRQ_MASK);

   // Ack toggles, so a held request sees exactly one stall cycle
   always @(posedge clock) begin
      if (srst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   assign cfg_eff = {config_field_b2_effective,
      config_field_b1_effective, ext_reset_disable_effective};

   always @* begin
      rd_next = 8'h00;
      case (word_idx)
         `RSC_IDX_CAUSE: begin
            // Clear-request bit is write-only and reads as zero
            rd_next = {1'b0, cause_reg};
         end
         `RSC_IDX_CONFIG: begin
            rd_next = {5'h00, cfg_wr_reg};
         end
         `RSC_IDX_COMMIT: begin
            // Reads here see effective values, writes hit commit
            rd_next = {5'h00, cfg_eff};
         end
         `RSC_IDX_IRQ_STAT: begin
            rd_next = evt_stat_reg;
         end
         `RSC_IDX_IRQ_MASK: begin
            rd_next = evt_mask_reg;
         end
         default: begin
            // Unmapped words read as zero
            rd_next = 8'h00;
         end
      endcase
   end

   // Loaded in the stall cycle so data stands when ack rises
   always @(posedge clock) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & ~ack_reg) begin
         avs_readdata <= {24'h00_0000, rd_next};
      end
   end

   // ----------------------------------------
   // Commit decode
   // ----------------------------------------
   // Full-byte compare: any other value does nothing at all.
   // Software must not read-modify-write this port since the
   // read returns status, not the code
   assign commit_dis = wr_take & sel_commit &
      (wdata == `RSC_CODE_DISABLE);
   assign commit_fields = wr_take & sel_commit &
      (wdata == `RSC_CODE_FIELDS);
   assign commit_fclr = wr_take & sel_commit & fclr_reg &
      (wdata == `RSC_CODE_FLAGCLR);

   // ----------------------------------------
   // Written configuration and clear request
   // ----------------------------------------
   // Any reset wipes values not yet committed
   always @(posedge clock) begin
      if (any_reset) begin
         cfg_wr_reg <= `RSC_CFG_RST;
      end else if (wr_take & sel_config) begin
         cfg_wr_reg <= wdata[`RSC_CFG_W-1:0];
      end
   end

   // ----------------------------------------
   // Flag-clear request
   // ----------------------------------------
   // Write-only bit: software arms it, the matching commit uses it up
   always @(posedge clock) begin
      if (any_reset) begin
         fclr_reg <= 1'b0;
      end else if (commit_fclr) begin
         fclr_reg <= 1'b0;
      end else if (wr_take & sel_cause) begin
         fclr_reg <= wdata[`RSC_FCLR_BIT];
      end
   end

   // ----------------------------------------
   // Effective configuration
   // ----------------------------------------
   // Disable bit survives external and internal resets so a
   // blocked pin stays blocked until power is cycled
   always @(posedge clock) begin
      if (por_any) begin
         ext_reset_disable_effective <= 1'b0;
      end else if (commit_dis) begin
         // Copied even when equal to the current value
         ext_reset_disable_effective <=
            cfg_wr_reg[`RSC_CFG_DIS];
      end
   end

   // Both fields share one commit code but keep their own flops
   always @(posedge clock) begin
      if (por_any) begin
         config_field_b1_effective <= 1'b0;
      end else if (commit_fields) begin
         config_field_b1_effective <=
            cfg_wr_reg[`RSC_CFG_B1];
      end
   end

   always @(posedge clock) begin
      if (por_any) begin
         config_field_b2_effective <= 1'b0;
      end else if (commit_fields) begin
         config_field_b2_effective <=
            cfg_wr_reg[`RSC_CFG_B2];
      end
   end

   // ----------------------------------------
   // Reset cause flags
   // ----------------------------------------
   // Order: flash, bad trim, trim, vdet2, vdet1, sysclk, wdt
   assign cause_src = {flash_standby_req, bad_trim_in,
      trim_req, vdet2_req, vdet1_req, sysclk_req,
      watchdog_req};

   // ----------------------------------------
   // Flag clear sources
   // ----------------------------------------
   // Internal resets are absent here so flags survive them
   assign flag_clear = por_any | ext_req | commit_fclr;

   genvar gi;
   generate
      for (gi = 0; gi < `RSC_CAUSE_W; gi = gi + 1) begin : g_cause
         // Set wins over a clear in the same cycle
         always @(posedge clock) begin
            if (srst) begin
               cause_reg[gi] <= 1'b0;
            end else if (cause_src[gi]) begin
               cause_reg[gi] <= 1'b1;
            end else if (flag_clear) begin
               cause_reg[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Interrupt status and mask
   // ----------------------------------------
   // Same cause layout, bit 7 is the external pin reset
   assign evt_src = {ext_req, cause_src};

   generate
      for (gi = 0; gi < `RSC_EVT_W; gi = gi + 1) begin : g_evt
         always @(posedge clock) begin
            if (por_any) begin
               evt_stat_reg[gi] <= 1'b0;
            end else if (evt_src[gi]) begin
               evt_stat_reg[gi] <= 1'b1;
            end else if (wr_take & sel_stat & wdata[gi]) begin
               evt_stat_reg[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always @(posedge clock) begin
      if (por_any) begin
         evt_mask_reg <= `RSC_EVT_RST;
      end else if (wr_take & sel_mask) begin
         evt_mask_reg <= wdata;
      end
   end

   // ----------------------------------------
   // Interrupt output
   // ----------------------------------------
   // Level output; stays high while a masked-in bit is set
   assign irq = |(evt_stat_reg & evt_mask_reg);

endmodule // rsc_reset_ctrl

// >>> bench/rsc_chk.sv
`timescale 1ns/100ps
`include "rsc_map.vh"
module rsc_chk (
   // Clock and reset
   input wire clock,
   input wire srst,
   // Register bus
   input wire [`RSC_ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [`RSC_DATA_W-1:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   input wire [`RSC_DATA_W-1:0] avs_readdata,
   input wire avs_waitrequest,
   // Reset sources and outputs
   input wire por_req,
   input wire ext_reset_n_pin,
   input wire watchdog_req,
   input wire sys_reset,
   input wire warmup_start,
   input wire [15:0] reset_vector,
   input wire ext_reset_disable_effective,
   input wire config_field_b1_effective,
   input wire config_field_b2_effective
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   wire [11:0] idx = avs_address[13:2];
   wire rd_tk = avs_read && !avs_waitrequest;
   wire tk = avs_write && !avs_waitrequest && avs_byteenable[0] &&
      idx == `RSC_IDX_COMMIT;
   wire [7:0] wd = avs_writedata[7:0];
   // A blocked pin must not count, so the disable state is part of it
   sequence s_pin_low;
      (!ext_reset_n_pin && !ext_reset_disable_effective) [*3];
   endsequence
   sequence s_rst_end;
      sys_reset ##1 !sys_reset;
   endsequence
   a_vec_const: assert property (
      reset_vector == `RSC_RESET_VECTOR) else $error("vector wrong");
   a_warm_pulse: assert property (
      s_rst_end |-> ##[0:1] warmup_start ##1 !warmup_start)
      else $error("warm-up pulse missing");
   a_one_wait: assert property (
      $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("wait state count wrong");
   a_upper_zero: assert property (
      avs_readdata[31:8] == 24'h000000) else $error("upper data set");
   a_status_rd: assert property (
      rd_tk && idx == `RSC_IDX_COMMIT |-> avs_readdata[7:0] ==
      {5'h00, config_field_b2_effective, config_field_b1_effective,
      ext_reset_disable_effective}) else $error("status read wrong");
   a_cfg_upper: assert property (
      rd_tk && idx == `RSC_IDX_CONFIG |-> avs_readdata[7:3] == 5'h00)
      else $error("config upper bits set");
   a_fclr_zero: assert property (
      rd_tk && idx == `RSC_IDX_CAUSE |-> !avs_readdata[7])
      else $error("clear bit read as one");
   a_dis_hold: assert property (
      $changed(ext_reset_disable_effective) |-> $past(srst) ||
      $past(por_req) || $past(por_req, 2) ||
      $past(tk && wd == `RSC_CODE_DISABLE)) else $error("disable moved");
   a_fld_hold: assert property (
      $changed({config_field_b2_effective, config_field_b1_effective})
      |-> $past(srst) || $past(por_req) || $past(por_req, 2) ||
      $past(tk && wd == `RSC_CODE_FIELDS)) else $error("fields moved");
   a_wd_merge: assert property (
      watchdog_req |=> sys_reset) else $error("watchdog not merged");
   a_pin_reset: assert property (
      s_pin_low |=> sys_reset) else $error("pin reset missing");
endmodule // rsc_chk

// >>> bench/tb_reset_source_control.sv
`timescale 1ns/100ps
`include "rsc_map.vh"
module tb_reset_source_control;
   reg clock = 1'b0;
   reg srst = 1'b1;
   reg [13:0] avs_address = 14'h0000;
   reg avs_read = 1'b0;
   reg avs_write = 1'b0;
   reg [31:0] avs_writedata = 32'h0;
   reg [3:0] avs_byteenable = 4'hF;
   reg por_req = 1'b0;
   reg ext_reset_n_pin = 1'b1;
   // Internal requests, laid out like the cause flags
   reg [6:0] rq = 7'h00;
   wire watchdog_req = rq[0];
   wire sysclk_req = rq[1];
   wire vdet1_req = rq[2];
   wire vdet2_req = rq[3];
   wire trim_req = rq[4];
   wire bad_trim_in = rq[5];
   wire flash_standby_req = rq[6];
   wire [31:0] avs_readdata;
   wire avs_waitrequest, sys_reset, por_reset, warmup_start, irq;
   wire [15:0] reset_vector;
   wire ext_reset_disable_effective;
   wire config_field_b1_effective, config_field_b2_effective;
   integer n_mismatch = 0;
   integer compares = 0;
   integer i;
   reg [31:0] q;
   reg [6:0] fl;
   always #4 clock = ~clock;
   rsc_reset_ctrl rsc_reset_ctrl_i (
      .clock(clock),
      .srst(srst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .por_req(por_req),
      .ext_reset_n_pin(ext_reset_n_pin),
      .vdet1_req(vdet1_req),
      .vdet2_req(vdet2_req),
      .watchdog_req(watchdog_req),
      .sysclk_req(sysclk_req),
      .trim_req(trim_req),
      .flash_standby_req(flash_standby_req),
      .bad_trim_in(bad_trim_in),
      .sys_reset(sys_reset),
      .por_reset(por_reset),
      .warmup_start(warmup_start),
      .reset_vector(reset_vector),
      .ext_reset_disable_effective(ext_reset_disable_effective),
      .config_field_b1_effective(config_field_b1_effective),
      .config_field_b2_effective(config_field_b2_effective),
      .irq(irq)
   );
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task give_verdict; begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end endtask
   task chk(input [31:0] g, input [31:0] e); begin
      compares = compares + 1;
      if (g !== e) begin
         n_mismatch = n_mismatch + 1;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   end endtask
   task bus(input w, input [11:0] ix, input [7:0] d);
      integer n;
      begin
         avs_address <= {ix, 2'b00};
         // Commit port only ever gets plain writes
         avs_writedata <= {24'h000000, d};
         avs_write <= w;
         avs_read <= !w;
         n = 0;
         do begin
            @(posedge clock);
            n = n + 1;
         end while (avs_waitrequest !== 1'b0 && n < 50);
         chk(n < 50, 1'b1);
         if (n >= 50) give_verdict;
         q = avs_readdata;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
         // A spare edge keeps the next request off this edge
         @(posedge clock);
      end
   endtask
   task rd(input [11:0] ix, input [31:0] e); begin
      bus(1'b0, ix, 8'h00);
      chk(q, e);
   end endtask
   task wr(input [11:0] ix, input [7:0] d); begin
      bus(1'b1, ix, d);
   end endtask
   task wait_rst(input v);
      integer n;
      begin
         n = 0;
         while (sys_reset !== v && n < 50) begin
            @(posedge clock);
            n = n + 1;
         end
         chk(n < 50, 1'b1);
         if (n >= 50) give_verdict;
         @(posedge clock);
      end
   endtask
   task pulse(input integer b); begin
      rq[b] <= 1'b1;
      repeat (2) @(posedge clock);
      rq <= 7'h00;
      wait_rst(1'b0);
   end endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset; begin
      rd(`RSC_IDX_CAUSE, 32'h0);
      rd(`RSC_IDX_CONFIG, 32'h0);
      rd(`RSC_IDX_COMMIT, 32'h0);
      wr(12'h100, 8'hFF);
      rd(12'h100, 32'h0);
   end endtask
   task t_commit; begin
      wr(`RSC_IDX_CONFIG, 8'hFF);
      rd(`RSC_IDX_CONFIG, 32'h07);
      rd(`RSC_IDX_COMMIT, 32'h00);
      wr(`RSC_IDX_COMMIT, 8'h55);
      rd(`RSC_IDX_COMMIT, 32'h00);
      wr(`RSC_IDX_COMMIT, `RSC_CODE_FIELDS);
      rd(`RSC_IDX_COMMIT, 32'h06);
      wr(`RSC_IDX_COMMIT, `RSC_CODE_DISABLE);
      rd(`RSC_IDX_COMMIT, 32'h07);
   end endtask
   task t_block; begin
      ext_reset_n_pin <= 1'b0;
      repeat (6) @(posedge clock) chk(sys_reset, 1'b0);
      ext_reset_n_pin <= 1'b1;
      repeat (3) @(posedge clock);
   end endtask
   task t_causes; begin
      fl = 7'h00;
      for (i = 0; i < 7; i = i + 1) if (i != 5) begin
         pulse(i);
         fl[i] = 1'b1;
         rd(`RSC_IDX_CAUSE, fl);
      end
      rd(`RSC_IDX_CONFIG, 32'h00);
      rd(`RSC_IDX_COMMIT, 32'h07);
      rq[5] <= 1'b1;
      repeat (2) @(posedge clock);
      rq <= 7'h00;
      rd(`RSC_IDX_CAUSE, 32'h7F);
   end endtask
   task t_clear; begin
      wr(`RSC_IDX_COMMIT, `RSC_CODE_FLAGCLR);
      rd(`RSC_IDX_CAUSE, 32'h7F);
      wr(`RSC_IDX_CAUSE, 8'h80);
      rd(`RSC_IDX_CAUSE, 32'h7F);
      wr(`RSC_IDX_COMMIT, `RSC_CODE_FLAGCLR);
      rd(`RSC_IDX_CAUSE, 32'h00);
   end endtask
   task t_ext; begin
      wr(`RSC_IDX_CONFIG, 8'h00);
      wr(`RSC_IDX_COMMIT, `RSC_CODE_DISABLE);
      rd(`RSC_IDX_COMMIT, 32'h06);
      pulse(0);
      ext_reset_n_pin <= 1'b0;
      wait_rst(1'b1);
      ext_reset_n_pin <= 1'b1;
      wait_rst(1'b0);
      rd(`RSC_IDX_CAUSE, 32'h00);
      rd(`RSC_IDX_COMMIT, 32'h06);
      por_req <= 1'b1;
      repeat (2) @(posedge clock);
      chk(por_reset, 1'b1);
      por_req <= 1'b0;
      wait_rst(1'b0);
      chk(por_reset, 1'b0);
      rd(`RSC_IDX_COMMIT, 32'h00);
   end endtask
   task t_irq; begin
      rd(`RSC_IDX_IRQ_STAT, 32'h00);
      pulse(0);
      rd(`RSC_IDX_IRQ_STAT, 32'h01);
      wr(`RSC_IDX_IRQ_MASK, 8'h00);
      chk(irq, 1'b0);
      wr(`RSC_IDX_IRQ_MASK, 8'hFF);
      // A set mask bit lets its status bit through
      chk(irq, 1'b1);
      wr(`RSC_IDX_IRQ_STAT, 8'hFF);
      rd(`RSC_IDX_IRQ_STAT, 32'h00);
      chk(irq, 1'b0);
   end endtask
   initial begin
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      t_reset;
      t_commit;
      t_block;
      t_causes;
      t_clear;
      t_ext;
      t_irq;
      give_verdict;
   end
endmodule // tb_reset_source_control
bind rsc_reset_ctrl rsc_chk rsc_chk_i (.*);
